//--- shared/brake_pkg.sv
package brake_pkg;
    // =====================================================================
    // timing (40 MHz system clock)
    localparam int CLK_HZ = 40000000;
    localparam int LOAD_MEAS_MS = 200;
    localparam int LOAD_MEAS_CYC = LOAD_MEAS_MS * (CLK_HZ / 1000);
    localparam int APPLY_MS = 300;
    localparam int APPLY_CYC = APPLY_MS * (CLK_HZ / 1000);
    localparam int TORQUE_MS = 500;
    localparam int TORQUE_CYC = TORQUE_MS * (CLK_HZ / 1000);
    localparam int INTERVAL_MIN = 480;
    localparam longint INTERVAL_CYC = longint'(INTERVAL_MIN) * 60 * CLK_HZ;
    // =====================================================================
    // torque and angle scaling
    localparam int TEST_TORQUE_PCT = 130;
    localparam int PCT_DIV = 100;
    localparam int ARCMIN_PER_DEG = 60;
    localparam logic [15:0] TOL_RESET = 16'h012C;
    // =====================================================================
    // codes
    localparam logic [15:0] WARN_ASSIGN_CONFLICT = 16'h232F;
    localparam logic [1:0] AXIS_NONE = 2'h0;
    localparam logic [1:0] AXIS_ONE = 2'h1;
    localparam logic [1:0] AXIS_TWO = 2'h2;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_PASS = 2'h1;
    localparam logic [1:0] RES_FAIL = 2'h2;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LOAD = 6'h02,
        ST_APPLY = 6'h04,
        ST_TORQUE = 6'h08,
        ST_RELEASE = 6'h10,
        ST_DONE = 6'h20
    } test_state_type;
endpackage

//--- verilog/brake_channel.sv
`timescale 1ns/1ps
// =====================================================================
// per-brake wiring monitor: synchronises the open-circuit sense pin and
// classifies it as warning or fault from the enable state
module brake_channel
    import brake_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic open_circuit_i,
    input wire logic attached_i,
    input wire logic axis_enabled_i,
    input wire logic fault_report_flag_i,
    output logic io_fail_o,
    output logic io_warn_o,
    output logic io_fault_o
);
    logic sync_a;
    logic sync_b;
    logic next_warn;
    logic next_fault;
    logic warn;
    logic fault;

    // =====================================================================
    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= open_circuit_i;
            sync_b <= sync_a;
        end
    end

    // classification: disabled axis warns, enabled with flag faults
    always_comb
    begin
        next_warn = sync_b && attached_i && !axis_enabled_i;
        next_fault = sync_b && attached_i && axis_enabled_i && fault_report_flag_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            warn <= 1'b0;
            fault <= 1'b0;
        end
        else
        begin
            warn <= next_warn;
            fault <= next_fault;
        end
    end

    assign io_fail_o = sync_b && attached_i;
    assign io_warn_o = warn;
    assign io_fault_o = fault;

    property p_warn_when_disabled;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (sync_b && attached_i && !axis_enabled_i) |=> warn && !fault;
    endproperty
    a_warn_when_disabled: assert property (p_warn_when_disabled)
        else $error("io failure on disabled axis not a warning");

    property p_fault_when_enabled;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (sync_b && attached_i && axis_enabled_i && fault_report_flag_i) |=> fault && !warn;
    endproperty
    a_fault_when_enabled: assert property (p_fault_when_enabled)
        else $error("io failure on enabled axis not a fault");
endmodule

//--- verilog/brake_supervision_and_test.sv
`timescale 1ns/1ps
// Functional notes
// - per-axis brake-detected status
// - conflict raises warning 9007 while disabled
// - conflict refuses axis enable request
// - single-axis: axis 1 holds both brakes
// - both on axis 1: axis 2 none
// - dual-axis split: each axis own brake
// - both on axis 2: brake 1 unsupervised
// - open brake circuit: io failure, stops
// - disabled drive reports io failure as warning
// - enabled with flag set: fault
// - test drives torque against engaged brake
// - motion within tolerance: test passes
// - motion beyond tolerance: fail, functions lost
// - test torque is 130 percent load
// - slip resolution one degree or finer
// - each brake has own tolerance
// - test only on safe-held brakes
// - up to 200 ms load measurement first
// - test-ok state reflects recent pass
module brake_supervision_and_test
    import brake_pkg::*;
#(
    parameter int LOAD_CYCLES = LOAD_MEAS_CYC,
    parameter int APPLY_CYCLES = APPLY_CYC,
    parameter int TORQUE_CYCLES = TORQUE_CYC,
    parameter longint INTERVAL_CYCLES = INTERVAL_CYC,
    parameter bit DUAL_AXIS = 1'b1
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] brake1_axis_i,
    input wire logic [1:0] brake2_axis_i,
    input wire logic [1:0] safe_hold_cfg_i,
    input wire logic [1:0] open_circuit_i,
    input wire logic [1:0] axis_enable_req_i,
    input wire logic [1:0] cutoff_fault_report_flag_i,
    input wire logic [1:0] brake_hold_req_i,
    input wire logic test_start_i,
    input wire logic test_brake_sel_i,
    input wire logic [15:0] tol1_arcmin_i,
    input wire logic [15:0] tol2_arcmin_i,
    input wire logic [15:0] app_load_i,
    input wire logic [15:0] motion_arcmin_i,
    output logic [1:0] brake_detected_o,
    output logic [1:0] axis_enabled_o,
    output logic [15:0] warning_code_o,
    output logic [1:0] brake_drive_o,
    output logic [1:0] brake_supervised_o,
    output logic [1:0] io_warn_o,
    output logic [1:0] io_fault_o,
    output logic [1:0] fault_stop_o,
    output logic [15:0] test_torque_o,
    output logic test_busy_o,
    output logic [1:0] result1_o,
    output logic [1:0] result2_o,
    output logic brake_test_ok_state_o
);
    localparam int CW = 32;
    localparam int IW = 41;

    // the age counter must reach the interval; 480 min needs 41 bits
    generate
        if (LOAD_CYCLES < 1 || APPLY_CYCLES < 1 || TORQUE_CYCLES < 1 || INTERVAL_CYCLES < 1
            || INTERVAL_CYCLES >= (longint'(1) << IW))
        begin : gen_bad_timing
            $error("timing counts out of range");
        end
    endgenerate

    // =====================================================================
    // arbitration: which axis owns each brake with safe supervision
    function automatic logic owns(input logic [1:0] asg, input logic [1:0] ax);
        owns = (asg == ax);
    endfunction

    logic [1:0] ctrl1;
    logic [1:0] ctrl2;
    logic [1:0] conflict;
    logic [1:0] sup;
    logic [1:0] attached;

    always_comb
    begin
        ctrl1 = DUAL_AXIS ? brake1_axis_i : AXIS_ONE;
        ctrl2 = DUAL_AXIS ? brake2_axis_i : AXIS_ONE;
        // brake 1 on axis 2 runs unsupervised; axis 2 blocked if both on 1 and its safe hold is set
        sup[0] = owns(ctrl1, AXIS_ONE);
        sup[1] = owns(ctrl2, AXIS_ONE) || owns(ctrl2, AXIS_TWO);
        attached[0] = owns(ctrl1, AXIS_ONE) || owns(ctrl2, AXIS_ONE);
        attached[1] = owns(ctrl1, AXIS_TWO) || owns(ctrl2, AXIS_TWO);
        // safe hold config per axis must be served by a supervised brake
        conflict[0] = safe_hold_cfg_i[0] && !(sup[0] || (sup[1] && owns(ctrl2, AXIS_ONE)));
        conflict[1] = safe_hold_cfg_i[1] && !(sup[1] && owns(ctrl2, AXIS_TWO));
    end

    // =====================================================================
    // wiring monitors, one per brake output
    logic [1:0] fail_b;
    logic [1:0] warn_b;
    logic [1:0] fault_b;
    logic [1:0] enab;
    logic [1:0] brake_axis_en;
    logic [1:0] brake_flag;
    logic [1:0] en_ok;

    assign en_ok = axis_enable_req_i & ~conflict;
    // classify on the allowed request: the stop it triggers must not turn a fault into a warning
    assign brake_axis_en[0] = owns(ctrl1, AXIS_TWO) ? en_ok[1] : en_ok[0];
    assign brake_axis_en[1] = owns(ctrl2, AXIS_TWO) ? en_ok[1] : en_ok[0];
    assign brake_flag[0] = owns(ctrl1, AXIS_TWO) ? cutoff_fault_report_flag_i[1]
                                                 : cutoff_fault_report_flag_i[0];
    assign brake_flag[1] = owns(ctrl2, AXIS_TWO) ? cutoff_fault_report_flag_i[1]
                                                 : cutoff_fault_report_flag_i[0];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_chan
            brake_channel u_chan (
                .sys_clk_i(sys_clk_i),
                .rst_b_i(rst_b_i),
                .open_circuit_i(open_circuit_i[g]),
                .attached_i((g == 0) ? (ctrl1 != AXIS_NONE) : (ctrl2 != AXIS_NONE)),
                .axis_enabled_i(brake_axis_en[g]),
                .fault_report_flag_i(brake_flag[g]),
                .io_fail_o(fail_b[g]),
                .io_warn_o(warn_b[g]),
                .io_fault_o(fault_b[g])
            );
        end
    endgenerate

    // =====================================================================
    // test sequencer
    test_state_type state;
    test_state_type next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic sel;
    logic next_sel;
    logic [15:0] torque;
    logic [15:0] next_torque;
    logic slip;
    logic next_slip;
    logic [1:0] res1;
    logic [1:0] next_res1;
    logic [1:0] res2;
    logic [1:0] next_res2;
    logic [IW-1:0] age;
    logic [IW-1:0] next_age;
    logic ok;
    logic next_ok;
    logic busy;
    logic next_busy;
    logic [15:0] tol_sel;
    logic sel_sup;
    logic [31:0] scaled;

    assign tol_sel = sel ? tol2_arcmin_i : tol1_arcmin_i;
    assign sel_sup = test_brake_sel_i ? sup[1] : sup[0];
    assign scaled = (32'(app_load_i) * 32'(TEST_TORQUE_PCT)) / 32'(PCT_DIV);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        next_sel = sel;
        next_torque = torque;
        next_slip = slip;
        next_res1 = res1;
        next_res2 = res2;
        next_age = (age < INTERVAL_CYCLES[IW-1:0]) ? age + 1'b1 : age;
        next_ok = ok && (age < INTERVAL_CYCLES[IW-1:0]);
        case (state)
            ST_IDLE:
            begin
                next_cnt = '0;
                if (test_start_i && sel_sup)
                begin
                    next_state = ST_LOAD;
                    next_sel = test_brake_sel_i;
                    next_slip = 1'b0;
                end
            end
            ST_LOAD:
            begin
                // load sampled continuously; the last sample sets the torque
                next_torque = (scaled > 32'h0000FFFF) ? 16'hFFFF : scaled[15:0];
                if (cnt >= CW'(LOAD_CYCLES - 1))
                begin
                    next_state = ST_APPLY;
                    next_cnt = '0;
                end
            end
            ST_APPLY:
            begin
                if (cnt >= CW'(APPLY_CYCLES - 1))
                begin
                    next_state = ST_TORQUE;
                    next_cnt = '0;
                end
            end
            ST_TORQUE:
            begin
                // arcmin compare is finer than the one degree required
                if (motion_arcmin_i > tol_sel)
                    next_slip = 1'b1;
                if (cnt >= CW'(TORQUE_CYCLES - 1))
                begin
                    next_state = ST_RELEASE;
                    next_cnt = '0;
                end
            end
            ST_RELEASE:
            begin
                if (cnt >= CW'(APPLY_CYCLES - 1))
                    next_state = ST_DONE;
            end
            ST_DONE:
            begin
                next_state = ST_IDLE;
                next_cnt = '0;
                if (sel)
                    next_res2 = slip ? RES_FAIL : RES_PASS;
                else
                    next_res1 = slip ? RES_FAIL : RES_PASS;
                next_ok = !slip;
                next_age = '0;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            sel <= 1'b0;
            torque <= 16'h0000;
            slip <= 1'b0;
            res1 <= RES_NONE;
            res2 <= RES_NONE;
            age <= '0;
            ok <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            sel <= next_sel;
            torque <= next_torque;
            slip <= next_slip;
            res1 <= next_res1;
            res2 <= next_res2;
            age <= next_age;
            ok <= next_ok;
            busy <= next_busy;
        end
    end

    // =====================================================================
    // enable gating, brake drive and status outputs
    logic [1:0] next_enab;
    logic [1:0] next_drive;
    logic [1:0] stop;
    logic [1:0] next_stop;
    logic [15:0] next_warn_code;
    logic in_test;

    assign in_test = (state == ST_APPLY) || (state == ST_TORQUE);

    always_comb
    begin
        // an open circuit stops the owning axis; a failed test stops axis 1 for brake 1, axis 2 for brake 2
        next_stop[0] = (fail_b[0] && !owns(ctrl1, AXIS_TWO)) || (fail_b[1] && !owns(ctrl2, AXIS_TWO))
                       || (res1 == RES_FAIL);
        next_stop[1] = (fail_b[0] && owns(ctrl1, AXIS_TWO)) || (fail_b[1] && owns(ctrl2, AXIS_TWO))
                       || (res2 == RES_FAIL);
        next_enab = en_ok & ~next_stop;
        next_warn_code = (|(conflict & ~enab)) ? WARN_ASSIGN_CONFLICT : 16'h0000;
        // brake released (drive high) unless holding or being tested
        next_drive[0] = !brake_hold_req_i[owns(ctrl1, AXIS_TWO)] && !(in_test && !sel);
        next_drive[1] = !brake_hold_req_i[owns(ctrl2, AXIS_TWO)] && !(in_test && sel);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            enab <= 2'b00;
            stop <= 2'b00;
            warning_code_o <= 16'h0000;
            brake_drive_o <= 2'b00;
            brake_supervised_o <= 2'b00;
            brake_detected_o <= 2'b00;
            test_torque_o <= 16'h0000;
        end
        else
        begin
            enab <= next_enab;
            stop <= next_stop;
            warning_code_o <= next_warn_code;
            brake_drive_o <= next_drive;
            brake_supervised_o <= sup;
            brake_detected_o <= attached;
            test_torque_o <= (state == ST_TORQUE) ? torque : 16'h0000;
        end
    end

    assign axis_enabled_o = enab;
    assign fault_stop_o = stop;
    assign io_warn_o = warn_b;
    assign io_fault_o = fault_b;
    assign test_busy_o = busy;
    assign result1_o = res1;
    assign result2_o = res2;
    assign brake_test_ok_state_o = ok;

    // =====================================================================
    property p_conflict_blocks_enable;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        conflict[0] |=> !enab[0];
    endproperty
    a_conflict_blocks_enable: assert property (p_conflict_blocks_enable)
        else $error("axis enabled despite assignment conflict");

    property p_conflict_warns;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (conflict[1] && !enab[1]) |=> warning_code_o == WARN_ASSIGN_CONFLICT;
    endproperty
    a_conflict_warns: assert property (p_conflict_warns)
        else $error("conflict warning code missing");

    property p_test_needs_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_IDLE && test_start_i && !sup[test_brake_sel_i]) |=> state == ST_IDLE;
    endproperty
    a_test_needs_hold: assert property (p_test_needs_hold)
        else $error("test started on unsupervised brake");

    property p_fail_sets_result;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_DONE && slip) |=> (sel ? res2 : res1) == RES_FAIL && !ok;
    endproperty
    a_fail_sets_result: assert property (p_fail_sets_result)
        else $error("slip did not fail the test");

    property p_pass_sets_ok;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_DONE && !slip) |=> ok;
    endproperty
    a_pass_sets_ok: assert property (p_pass_sets_ok)
        else $error("passing test did not set ok state");

    property p_result_stable;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (state != ST_DONE) |=> $stable(res1) && $stable(res2);
    endproperty
    a_result_stable: assert property (p_result_stable)
        else $error("test result changed outside completion");

    property p_single_axis_both;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !DUAL_AXIS |-> sup == 2'b11;
    endproperty
    a_single_axis_both: assert property (p_single_axis_both)
        else $error("single-axis drive does not supervise both brakes");

    property p_both_on_one;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (ctrl1 == AXIS_ONE && ctrl2 == AXIS_ONE) |-> !attached[1];
    endproperty
    a_both_on_one: assert property (p_both_on_one)
        else $error("axis 2 holds a brake owned by axis 1");

    property p_brake1_unsafe;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (ctrl1 == AXIS_TWO) |-> !sup[0];
    endproperty
    a_brake1_unsafe: assert property (p_brake1_unsafe)
        else $error("brake 1 supervised while on axis 2");
endmodule

//--- tb/brake_far_side.sv
`timescale 1ns/1ps
// =====================================================================
// brake and wiring model: a brake slips while test torque is applied,
// and a cut wire reads as an open brake circuit
module brake_far_side (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] test_torque_i,
    input wire logic test_busy_i,
    input wire logic [1:0] wire_cut_i,
    input wire logic [15:0] slip_step_i,
    output logic [1:0] open_circuit_o,
    output logic [15:0] motion_arcmin_o
);
    logic [15:0] motion;
    logic [15:0] next_motion;

    // a cut wire is seen at once; the design has to synchronise it
    assign open_circuit_o = wire_cut_i;
    assign motion_arcmin_o = motion;

    // slip only grows under torque, so a lazy torque phase shows no motion
    always_comb
    begin
        next_motion = motion;
        if (test_busy_i !== 1'b1)
            next_motion = 16'h0000;
        else if (test_torque_i != 16'h0000)
            next_motion = motion + slip_step_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            motion <= 16'h0000;
        else
            motion <= next_motion;
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// bench for the brake supervisor with shortened test phases
module tb_top;
    import brake_pkg::*;
    localparam int LOAD_C = 4;
    localparam int APPLY_C = 4;
    localparam int TORQUE_C = 8;
    localparam longint INT_C = 200;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [1:0] brake1_axis = 2'h0;
    logic [1:0] brake2_axis = 2'h0;
    logic [1:0] safe_hold_cfg = 2'h0;
    logic [1:0] open_circuit;
    logic [1:0] axis_enable_req = 2'h0;
    logic [1:0] flag = 2'h0;
    logic [1:0] hold_req = 2'h0;
    logic test_start = 1'b0;
    logic test_sel = 1'b0;
    logic [15:0] tol1 = 16'h012C;
    logic [15:0] tol2 = 16'h0032;
    logic [15:0] app_load = 16'h03E8;
    logic [15:0] motion;
    logic [1:0] wire_cut = 2'h0;
    logic [15:0] slip_step = 16'h0014;
    logic [1:0] detected, enabled, drive, supervised, io_warn, io_fault, stop, res1, res2;
    logic [15:0] warn_code, torque;
    logic busy, ok;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    brake_supervision_and_test #(.LOAD_CYCLES(LOAD_C), .APPLY_CYCLES(APPLY_C),
        .TORQUE_CYCLES(TORQUE_C), .INTERVAL_CYCLES(INT_C), .DUAL_AXIS(1'b1)) dut (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .brake1_axis_i(brake1_axis),
        .brake2_axis_i(brake2_axis),
        .safe_hold_cfg_i(safe_hold_cfg),
        .open_circuit_i(open_circuit),
        .axis_enable_req_i(axis_enable_req),
        .cutoff_fault_report_flag_i(flag),
        .brake_hold_req_i(hold_req),
        .test_start_i(test_start),
        .test_brake_sel_i(test_sel),
        .tol1_arcmin_i(tol1),
        .tol2_arcmin_i(tol2),
        .app_load_i(app_load),
        .motion_arcmin_i(motion),
        .brake_detected_o(detected),
        .axis_enabled_o(enabled),
        .warning_code_o(warn_code),
        .brake_drive_o(drive),
        .brake_supervised_o(supervised),
        .io_warn_o(io_warn),
        .io_fault_o(io_fault),
        .fault_stop_o(stop),
        .test_torque_o(torque),
        .test_busy_o(busy),
        .result1_o(res1),
        .result2_o(res2),
        .brake_test_ok_state_o(ok)
    );

    brake_far_side far (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .test_torque_i(torque),
        .test_busy_i(busy),
        .wire_cut_i(wire_cut),
        .slip_step_i(slip_step),
        .open_circuit_o(open_circuit),
        .motion_arcmin_o(motion)
    );

    // =====================================================================
    // clock and hang guard; a whole run needs well under 2000 cycles
    always #12.5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            summarize();
        end
    end

    // =====================================================================
    // helpers
    task automatic summarize();
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(negedge sys_clk_i);
        rst_b_i = 1'b0;
        repeat (16) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        @(negedge sys_clk_i);
    endtask

    // config is level driven; three cycles covers the latency of up to two cycles (conflict warning waits on enab)
    task automatic cfg(input logic [1:0] b1, input logic [1:0] b2, input logic [1:0] safe,
        input logic [1:0] en, input logic [1:0] hold);
        @(negedge sys_clk_i);
        brake1_axis = b1;
        brake2_axis = b2;
        safe_hold_cfg = safe;
        axis_enable_req = en;
        hold_req = hold;
        repeat (3) @(negedge sys_clk_i);
    endtask

    // one test: start for a single edge, then follow busy under a bound
    task automatic run_test(input logic sel, input logic [1:0] exp_res);
        int n;
        logic [15:0] tmax;
        logic eng;
        n = 0;
        tmax = 16'h0000;
        eng = 1'b1;
        @(negedge sys_clk_i);
        test_sel = sel;
        test_start = 1'b1;
        @(negedge sys_clk_i);
        test_start = 1'b0;
        check("busy", 16'(busy), 16'h0001);
        while (busy === 1'b1 && n < 100)
        begin
            @(negedge sys_clk_i);
            n++;
            if (torque > tmax)
                tmax = torque;
            if (torque != 16'h0000 && drive[sel] !== 1'b0)
                eng = 1'b0;
        end
        check("engaged", 16'(eng), 16'h0001);
        check("cycles", 16'(n), 16'(LOAD_C + 2 * APPLY_C + TORQUE_C + 1));
        check("torque", tmax, 16'(32'(app_load) * TEST_TORQUE_PCT / PCT_DIV));
        check("result", 16'(sel ? res2 : res1), 16'(exp_res));
    endtask

    // =====================================================================
    // main sequence
    initial
    begin
        do_reset();
        check("ok", 16'(ok), 16'h0000);
        check("result1", 16'(res1), 16'h0000);
        check("warn", warn_code, 16'h0000);
        cfg(2'h1, 2'h2, 2'h3, 2'h3, 2'h1);
        check("sup", 16'(supervised), 16'h0003);
        check("det", 16'(detected), 16'h0003);
        check("drive", 16'(drive), 16'h0002);
        cfg(2'h1, 2'h1, 2'h1, 2'h3, 2'h1);
        check("sup", 16'(supervised), 16'h0003);
        check("det", 16'(detected), 16'h0001);
        check("drive", 16'(drive), 16'h0000);
        cfg(2'h2, 2'h2, 2'h3, 2'h3, 2'h1);
        check("sup", 16'(supervised), 16'h0002);
        check("drive", 16'(drive), 16'h0003);
        check("warn", warn_code, WARN_ASSIGN_CONFLICT);
        check("en", 16'(enabled), 16'h0002);
        // start on the unsupervised brake must be ignored
        cfg(2'h2, 2'h2, 2'h2, 2'h3, 2'h0);
        test_start = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        test_start = 1'b0;
        check("busy", 16'(busy), 16'h0000);
        cfg(2'h1, 2'h2, 2'h3, 2'h3, 2'h0);
        run_test(1'b0, RES_PASS);
        check("ok", 16'(ok), 16'h0001);
        repeat (190) @(negedge sys_clk_i);
        check("ok", 16'(ok), 16'h0001);
        repeat (15) @(negedge sys_clk_i);
        check("ok", 16'(ok), 16'h0000);
        run_test(1'b0, RES_PASS);
        run_test(1'b1, RES_FAIL);
        repeat (2) @(negedge sys_clk_i);
        check("result1", 16'(res1), 16'(RES_PASS));
        check("stop", 16'(stop), 16'h0002);
        check("ok", 16'(ok), 16'h0000);
        // wiring faults from a clean start
        do_reset();
        cfg(2'h1, 2'h2, 2'h3, 2'h0, 2'h0);
        wire_cut = 2'h1;
        repeat (5) @(negedge sys_clk_i);
        check("io_warn", 16'(io_warn), 16'h0001);
        check("io_fault", 16'(io_fault), 16'h0000);
        flag = 2'h3;
        cfg(2'h1, 2'h2, 2'h3, 2'h3, 2'h0);
        repeat (2) @(negedge sys_clk_i);
        check("io_fault", 16'(io_fault), 16'h0001);
        check("stop", 16'(stop), 16'h0001);
        summarize();
    end
endmodule
